// >>> hw/reset_ctrl_pkg.sv
// Package for the reset source controller: cause bit positions, widths,
// sequencing counts and identification register count and width.
// Assumes a single 100 MHz system clock domain.
package reset_ctrl_pkg;

  // Clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;

  // Number of reset sources.
  localparam int NUM_SOURCES = 5;

  // Reset cause bit positions.
  localparam int CAUSE_EXT = 0;
  localparam int CAUSE_POR = 1;
  localparam int CAUSE_BOR = 2;
  localparam int CAUSE_SW  = 3;
  localparam int CAUSE_WDT = 4;

  // Reset value of the cause register.
  localparam logic [4:0] CAUSE_RESET = 5'h00;

  // Software reset register geometry.
  localparam int SRCR_COUNT = 3;
  localparam int SRCR_WIDTH = 32;

  // Internal reset hold after all sources go quiet, in nanoseconds.
  localparam int HOLD_TIME_NS = 80;
  localparam int HOLD_CYCLES  =
    (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of the watchdog counter.
  localparam int WDT_WIDTH = 32;

  // Identification register count and width.
  localparam int IDENT_COUNT = 7;
  localparam int IDENT_WIDTH = 32;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_HOLD    = 2'b00,
    ST_COUNT   = 2'b01,
    ST_RUN     = 2'b10
  } seq_state_t;

endpackage

// >>> hw/reset_source_controller.sv
// Reset source controller: merges five reset sources into the system reset,
// records the cause, pulses peripheral resets and hosts the watchdog.
// Assumes supply monitors give levels; the reset pin is asynchronous.
//
// Contract
// - Five sources: pin, power-on, brown-out, software, watchdog.
// - The cause bit of each reset is set and stays set afterwards.
// - A power-on reset clears all other cause bits, leaving only power-on.
// - Pin reset resets core and peripherals, not the test port.
// - After pin release, synchronize a few cycles, then release reset.
// - Power-up holds reset until both pin and power-on end.
// - Power-on reset acts only at initial power-up.
// - Power-on reset also resets the test access port.
// - Brown-out reset is disabled out of reset until software enables; the module uses i_brownout_reset_enable as driven, with no reset value.
// - Brown-out raises an interrupt or a reset as configured.
// - Brown-out resets only while its reset-enable bit is set.
// - Brown-out reset acts like pin reset, held until supply recovers.
// - Setting then clearing a peripheral's soft reset bit resets it.
// - Soft reset bits follow clock gating layout; all unit domains reset; the module gives one reset per unit and leaves the fan-out to the consumer.
// - A system reset request resets the whole system, then releases.
// - Watchdog interrupts on first time-out, requests reset on second.
// - After the first time-out the counter reloads and counts down.
// - Second zero resets only with interrupt uncleared and reset enabled.
// - Seven read-only identification registers report device information.
`timescale 1ns/10ps

module reset_source_controller
  import reset_ctrl_pkg::*;
#(
  parameter int         UNIT_DOMAINS = 2,
  parameter logic [31:0] IDENT_VALUE0 = 32'h0001_0000, // Arbitrary value.
  parameter logic [31:0] IDENT_VALUE1 = 32'h0002_0000, // Arbitrary value.
  parameter logic [31:0] CAP_VALUE0   = 32'h0000_0000,
  parameter logic [31:0] CAP_VALUE1   = 32'h0000_0000,
  parameter logic [31:0] CAP_VALUE2   = 32'h0000_0000,
  parameter logic [31:0] CAP_VALUE3   = 32'h0000_0000,
  parameter logic [31:0] CAP_VALUE4   = 32'h0000_0000
)
(
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_ext_reset_n,
  input  wire logic                    i_power_on,
  input  wire logic                    i_brown_out,
  input  wire logic                    i_brownout_reset_enable,
  input  wire logic                    i_brownout_int_enable,
  input  wire logic                    i_system_reset_request,
  input  wire logic [SRCR_WIDTH-1:0]   i_soft_reset0,
  input  wire logic [SRCR_WIDTH-1:0]   i_soft_reset1,
  input  wire logic [SRCR_WIDTH-1:0]   i_soft_reset2,
  input  wire logic                    i_wdt_enable,
  input  wire logic                    i_wdt_reset_enable,
  input  wire logic [WDT_WIDTH-1:0]    i_watchdog_reload_value,
  input  wire logic                    i_wdt_load,
  input  wire logic                    i_wdt_int_clear,
  input  wire logic [4:0]              i_cause_clear,
  input  wire logic [2:0]              i_ident_sel,
  output logic                         o_sys_reset,
  output logic                         o_tap_reset,
  output logic [SRCR_WIDTH-1:0]        o_periph_reset0,
  output logic [SRCR_WIDTH-1:0]        o_periph_reset1,
  output logic [SRCR_WIDTH-1:0]        o_periph_reset2,
  output logic [4:0]                   o_reset_cause,
  output logic                         o_brownout_int,
  output logic                         o_wdt_int,
  output logic [WDT_WIDTH-1:0]         o_wdt_count,
  output logic [IDENT_WIDTH-1:0]       o_ident_data
);

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------

  logic [1:0] ext_sync_reg;
  logic [1:0] por_sync_reg;
  logic [1:0] bod_sync_reg;

  // Asynchronous levels pass two flops before any logic reads them.
  always_ff @(posedge i_clk)
  begin
    ext_sync_reg <= {ext_sync_reg[0], ~i_ext_reset_n};
    por_sync_reg <= {por_sync_reg[0], i_power_on};
    bod_sync_reg <= {bod_sync_reg[0], i_brown_out};
  end

  logic ext_active;
  logic por_level;
  logic bod_active;

  // Only the second stage of each synchroniser is used.
  assign ext_active = ext_sync_reg[1];
  assign por_level  = por_sync_reg[1];
  assign bod_active = bod_sync_reg[1];

  // ------------------------------------------------------------------
  // Power-on tracking
  // ------------------------------------------------------------------

  logic por_done_reg;
  logic por_active;

  // The power-on indication is honoured only until it first ends.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      por_done_reg <= 1'b0;
    else if (!por_level)
      por_done_reg <= 1'b1;
  end

  assign por_active = por_level & ~por_done_reg;

  // ------------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------------

  logic [WDT_WIDTH-1:0] wdt_count_reg;
  logic                 wdt_int_reg;
  logic                 wdt_reset_reg;
  logic                 wdt_zero;

  assign wdt_zero = (wdt_count_reg == '0);

  // Down-counter reloads on each time-out and on a software load.
  always_ff @(posedge i_clk)
  begin
    if (i_srst || o_sys_reset)
      wdt_count_reg <= '1;
    else if (i_wdt_load)
      wdt_count_reg <= i_watchdog_reload_value;
    else if (i_wdt_enable && wdt_zero)
      wdt_count_reg <= i_watchdog_reload_value;
    else if (i_wdt_enable)
      wdt_count_reg <= wdt_count_reg - 1'b1;
  end

  // First time-out sets the interrupt; a new time-out wins over a clear.
  always_ff @(posedge i_clk)
  begin
    if (i_srst || o_sys_reset)
      wdt_int_reg <= 1'b0;
    else if (i_wdt_enable && wdt_zero)
      wdt_int_reg <= 1'b1;
    else if (i_wdt_int_clear)
      wdt_int_reg <= 1'b0;
  end

  // Second time-out with the interrupt still pending requests a reset.
  always_ff @(posedge i_clk)
  begin
    if (i_srst || o_sys_reset)
      wdt_reset_reg <= 1'b0;
    else if (i_wdt_enable && wdt_zero && wdt_int_reg
             && i_wdt_reset_enable)
      wdt_reset_reg <= 1'b1;
  end

  // ------------------------------------------------------------------
  // Brown-out handling
  // ------------------------------------------------------------------

  logic bor_reset;

  // Brown-out resets only while enabled; the enable port is used as driven, with no reset.
  assign bor_reset = bod_active & i_brownout_reset_enable;

  // Brown-out raises the interrupt when not configured to reset.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_brownout_int <= 1'b0;
    else
      o_brownout_int <= bod_active & i_brownout_int_enable
                        & ~i_brownout_reset_enable;
  end

  // ------------------------------------------------------------------
  // Software system reset request
  // ------------------------------------------------------------------

  logic sysreq_d_reg;
  logic sw_pulse;

  // A rising request edge starts one system reset sequence.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      sysreq_d_reg <= 1'b0;
    else
      sysreq_d_reg <= i_system_reset_request;
  end

  assign sw_pulse = i_system_reset_request & ~sysreq_d_reg;

  // ------------------------------------------------------------------
  // Reset sequencer
  // ------------------------------------------------------------------

  localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);

  seq_state_t         state_reg;
  logic [HOLD_W-1:0]  hold_cnt_reg;
  logic               any_source;

  // Level sources hold reset; the pulse sources start a hold.
  assign any_source = ext_active | por_active | bor_reset
                      | sw_pulse | wdt_reset_reg;

  // Reset stays asserted while any source is active, then counts down.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state_reg    <= ST_HOLD;
      hold_cnt_reg <= HOLD_W'(HOLD_CYCLES);
    end
    else if (any_source)
    begin
      state_reg    <= ST_HOLD;
      hold_cnt_reg <= HOLD_W'(HOLD_CYCLES);
    end
    else
    begin
      case (state_reg)
        ST_HOLD:
          state_reg <= ST_COUNT;
        ST_COUNT:
        begin
          if (hold_cnt_reg == HOLD_W'(1))
            state_reg <= ST_RUN;
          hold_cnt_reg <= hold_cnt_reg - HOLD_W'(1);
        end
        ST_RUN:
          state_reg <= ST_RUN;
        default:
          state_reg <= ST_HOLD;
      endcase
    end
  end

  // System reset covers the core and all peripherals.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_sys_reset <= 1'b1;
    else
      o_sys_reset <= any_source || (state_reg != ST_RUN);
  end

  // The test port is reset by power-on only, never by the pin.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_tap_reset <= 1'b1;
    else
      o_tap_reset <= por_active;
  end

  // ------------------------------------------------------------------
  // Reset cause recording
  // ------------------------------------------------------------------

  logic [4:0] cause_set;

  // Collect this cycle's cause events.
  always_comb
  begin
    cause_set            = 5'h00;
    cause_set[CAUSE_EXT] = ext_active;
    cause_set[CAUSE_POR] = por_active;
    cause_set[CAUSE_BOR] = bor_reset;
    cause_set[CAUSE_SW]  = sw_pulse;
    cause_set[CAUSE_WDT] = wdt_reset_reg;
  end

  // Sticky bits; set wins over clear; power-on wipes all others.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_reset_cause <= CAUSE_RESET;
    else if (por_active)
      o_reset_cause <= 5'h01 << CAUSE_POR;
    else
      o_reset_cause <= (o_reset_cause & ~i_cause_clear) | cause_set;
  end

  // ------------------------------------------------------------------
  // Peripheral soft resets
  // ------------------------------------------------------------------

  logic [SRCR_WIDTH-1:0] soft_now [SRCR_COUNT];
  logic [SRCR_WIDTH-1:0] soft_armed_reg [SRCR_COUNT];
  logic [SRCR_WIDTH-1:0] periph_rst [SRCR_COUNT];

  assign soft_now[0] = i_soft_reset0;
  assign soft_now[1] = i_soft_reset1;
  assign soft_now[2] = i_soft_reset2;

  // A unit is held in reset while its bit is set and for one cycle after it clears.
  // Bit positions follow the clock gating layout, one reset per unit,
  // fanned out to every clock domain of that unit by the consumer.
  always_ff @(posedge i_clk)
  begin
    for (int i = 0; i < SRCR_COUNT; i++)
    begin
      if (i_srst)
      begin
        soft_armed_reg[i] <= '0;
        periph_rst[i]     <= '1;
      end
      else
      begin
        soft_armed_reg[i] <= soft_now[i];
        periph_rst[i]     <= soft_now[i] | soft_armed_reg[i]
                             | {SRCR_WIDTH{o_sys_reset}};
      end
    end
  end

  assign o_periph_reset0 = periph_rst[0];
  assign o_periph_reset1 = periph_rst[1];
  assign o_periph_reset2 = periph_rst[2];

  // ------------------------------------------------------------------
  // Identification and watchdog view
  // ------------------------------------------------------------------

  logic [IDENT_WIDTH-1:0] ident_rom [IDENT_COUNT];

  assign ident_rom[0] = IDENT_VALUE0;
  assign ident_rom[1] = IDENT_VALUE1;
  assign ident_rom[2] = CAP_VALUE0;
  assign ident_rom[3] = CAP_VALUE1;
  assign ident_rom[4] = CAP_VALUE2;
  assign ident_rom[5] = CAP_VALUE3;
  assign ident_rom[6] = CAP_VALUE4;

  // Read-only identification selected by index; out of range reads zero.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_ident_data <= '0;
    else if (int'(i_ident_sel) < IDENT_COUNT)
      o_ident_data <= ident_rom[i_ident_sel];
    else
      o_ident_data <= '0;
  end

  // Registered copies of watchdog state.
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_wdt_int   <= 1'b0;
      o_wdt_count <= '0;
    end
    else
    begin
      o_wdt_int   <= wdt_int_reg;
      o_wdt_count <= wdt_count_reg;
    end
  end

endmodule

// >>> test/reset_far_side.sv
// Far-side model: reset pin and the two supply monitor levels.
// Assumes the bench requests levels by non-blocking assignment at the edge.
`timescale 1ns/10ps
module reset_far_side
(
  input  wire logic i_clk,
  input  wire logic i_pin_low,
  input  wire logic i_supply_ramp,
  input  wire logic i_supply_sag,
  output logic      o_ext_reset_n,
  output logic      o_power_on,
  output logic      o_brown_out
);
  // Power comes up with the pin held low and the ramp monitor active.
  initial
  begin
    o_ext_reset_n = 1'h0;
    o_power_on = 1'h1;
    o_brown_out = 1'h0;
  end

  // Levels move 3 ns after the edge, out of step with the clock.
  always @(posedge i_clk)
  begin
    #3;
    o_ext_reset_n = !i_pin_low;
    o_power_on = i_supply_ramp;
    o_brown_out = i_supply_sag;
  end
endmodule

// >>> test/reset_source_controller_chk.sv
// Checker: port timing of the reset source controller.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module reset_source_controller_chk
  import reset_ctrl_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_srst,
  input wire logic                  i_ext_reset_n,
  input wire logic                  i_power_on,
  input wire logic                  i_brown_out,
  input wire logic                  i_brownout_reset_enable,
  input wire logic                  i_system_reset_request,
  input wire logic [SRCR_WIDTH-1:0] i_soft_reset0,
  input wire logic [4:0]            i_cause_clear,
  input wire logic                  o_sys_reset,
  input wire logic                  o_tap_reset,
  input wire logic [SRCR_WIDTH-1:0] o_periph_reset0,
  input wire logic [4:0]            o_reset_cause,
  input wire logic                  o_wdt_int
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  // Reset sources and their effect on the system, test port and peripheral resets.
  property p_pin_rst;
    !i_ext_reset_n [*4] |-> o_sys_reset;
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("pin reset not applied");
  property p_tap_pin;
    $fell(i_ext_reset_n) && !o_tap_reset && !i_power_on
      |=> !o_tap_reset [*3];
  endproperty
  a_tap_pin: assert property (p_tap_pin)
    else $error("pin reset reached test port");
  property p_pin_sync;
    $rose(i_ext_reset_n) && o_sys_reset |-> o_sys_reset [*8];
  endproperty
  a_pin_sync: assert property (p_pin_sync)
    else $error("release without synchronizing");
  property p_bor_rst;
    (i_brown_out && i_brownout_reset_enable) [*5] |-> o_sys_reset;
  endproperty
  a_bor_rst: assert property (p_bor_rst)
    else $error("brown-out reset missing");
  property p_sysreq;
    $rose(i_system_reset_request) |-> ##[1:4] o_sys_reset;
  endproperty
  a_sysreq: assert property (p_sysreq)
    else $error("system request ignored");
  property p_periph;
    |i_soft_reset0 |=>
      (o_periph_reset0 & $past(i_soft_reset0)) == $past(i_soft_reset0);
  endproperty
  a_periph: assert property (p_periph)
    else $error("peripheral reset missing");

  // Cause bits: pin bit sticky, power-on leaves only its own bit, watchdog cause follows the interrupt.
  property p_sticky;
    $fell(o_reset_cause[CAUSE_EXT])
      |-> $past(i_cause_clear[CAUSE_EXT]) || o_reset_cause[CAUSE_POR];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("cause bit lost");
  property p_por_only;
    $rose(o_reset_cause[CAUSE_POR]) |-> o_reset_cause == 5'h02;
  endproperty
  a_por_only: assert property (p_por_only)
    else $error("power-on cause not alone");
  property p_wdt_rst;
    $rose(o_reset_cause[CAUSE_WDT]) |-> $past(o_wdt_int);
  endproperty
  a_wdt_rst: assert property (p_wdt_rst)
    else $error("watchdog reset without interrupt");

  // Main scenarios reached.
  c_pin: cover property ($rose(o_reset_cause[CAUSE_EXT]));
  c_bor: cover property ($rose(o_reset_cause[CAUSE_BOR]));
  c_wdt: cover property ($rose(o_reset_cause[CAUSE_WDT]));
endmodule

bind reset_source_controller reset_source_controller_chk i_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_ext_reset_n(i_ext_reset_n),
  .i_power_on(i_power_on), .i_brown_out(i_brown_out),
  .i_brownout_reset_enable(i_brownout_reset_enable),
  .i_system_reset_request(i_system_reset_request),
  .i_soft_reset0(i_soft_reset0), .i_cause_clear(i_cause_clear),
  .o_sys_reset(o_sys_reset), .o_tap_reset(o_tap_reset),
  .o_periph_reset0(o_periph_reset0), .o_reset_cause(o_reset_cause),
  .o_wdt_int(o_wdt_int));

// >>> test/reset_source_controller_bench.sv
// Bench: power-up case, identification table loop, then directed reset-source cases.
// Assumes the far-side model drives the pin and supply monitor levels.
`timescale 1ns/10ps
module reset_source_controller_bench
  import reset_ctrl_pkg::*;
;
  localparam logic [31:0] ID_ROWS [8] = '{32'h0000_1001, 32'h0000_2002,
    32'h0000_00c0, 32'h0000_00c1, 32'h0000_00c2, 32'h0000_00c3,
    32'h0000_00c4, 32'h0000_0000}; // Arbitrary values.
  logic        clk = 1'h0;
  logic        srst, pin_low, ramp, sag, bor_en, bint_en, sysreq;
  logic        wdt_en, wdt_rst_en, wdt_ld, int_clr;
  logic        ext_n, pon, bout, sys, tap, bint, wint;
  logic [31:0] sr0, sr1, sr2, pr0, pr1, pr2, reload, wcnt, idd;
  logic [4:0]  cclr, cause;
  logic [2:0]  sel;
  int          n_errors = 0;
  int          n_tests = 0;

  // Clock of 10 ns.
  always #5 clk = !clk;

  reset_far_side i_far (.i_clk(clk), .i_pin_low(pin_low),
    .i_supply_ramp(ramp), .i_supply_sag(sag), .o_ext_reset_n(ext_n),
    .o_power_on(pon), .o_brown_out(bout));

  reset_source_controller #(.IDENT_VALUE0(ID_ROWS[0]),
    .IDENT_VALUE1(ID_ROWS[1]), .CAP_VALUE0(ID_ROWS[2]),
    .CAP_VALUE1(ID_ROWS[3]), .CAP_VALUE2(ID_ROWS[4]),
    .CAP_VALUE3(ID_ROWS[5]), .CAP_VALUE4(ID_ROWS[6])) i_dut (
    .i_clk(clk), .i_srst(srst), .i_ext_reset_n(ext_n), .i_power_on(pon),
    .i_brown_out(bout), .i_brownout_reset_enable(bor_en),
    .i_brownout_int_enable(bint_en), .i_system_reset_request(sysreq),
    .i_soft_reset0(sr0), .i_soft_reset1(sr1), .i_soft_reset2(sr2),
    .i_wdt_enable(wdt_en), .i_wdt_reset_enable(wdt_rst_en),
    .i_watchdog_reload_value(reload), .i_wdt_load(wdt_ld),
    .i_wdt_int_clear(int_clr), .i_cause_clear(cclr), .i_ident_sel(sel),
    .o_sys_reset(sys), .o_tap_reset(tap), .o_periph_reset0(pr0),
    .o_periph_reset1(pr1), .o_periph_reset2(pr2), .o_reset_cause(cause),
    .o_brownout_int(bint), .o_wdt_int(wint), .o_wdt_count(wcnt),
    .o_ident_data(idd));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Waits for the system reset (w=0) or the watchdog interrupt (w=1).
  task automatic wait_for(input logic w, input logic lvl, input int lim);
    int j;
    j = 0;
    #1;
    while ((w ? wint : sys) !== lvl && j < lim)
    begin
      @(posedge clk);
      #1;
      j++;
    end
    chk("wait level", 32'(lvl), 32'(w ? wint : sys));
    if ((w ? wint : sys) !== lvl)
      end_of_test();
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    srst = 1'h1;
    {sysreq, wdt_en, wdt_rst_en, wdt_ld, int_clr, bor_en, bint_en} = 7'h00;
    {sr0, sr1, sr2} = 96'h0;
    {pin_low, ramp, sag} = 3'h6;
    cclr = 5'h00;
    sel = 3'h0;
    reload = 32'h0000_0014;
    tick(4);
    srst <= 1'h0;
    #1 chk("sys_reset", 32'h1, 32'(sys));
    chk("cause", 32'h0, 32'(cause));
    // Ramp ends first; the pin keeps the system in reset.
    tick(9);
    #1 chk("cause", 32'h2, 32'(cause));
    chk("tap_reset", 32'h1, 32'(tap));
    tick(1);
    ramp <= 1'h0;
    tick(20);
    #1 chk("sys_reset", 32'h1, 32'(sys));
    tick(1);
    pin_low <= 1'h0;
    wait_for(1'h0, 1'h0, 40);
    // The pin outlasting the ramp is recorded beside power-on.
    chk("cause", 32'h3, 32'(cause));
    // Identification table.
    for (int i = 0; i < 8; i++)
    begin
      tick(1);
      sel <= 3'(i);
      tick(1);
      #1 chk("ident", ID_ROWS[i], idd);
    end
    // Pin reset spares the test port and sets a sticky cause bit.
    tick(1);
    pin_low <= 1'h1;
    tick(10);
    pin_low <= 1'h0;
    #1 chk("tap_reset", 32'h0, 32'(tap));
    tick(2);
    #1 chk("sys_reset", 32'h1, 32'(sys));
    wait_for(1'h0, 1'h0, 40);
    chk("cause", 32'h3, 32'(cause));
    // Causes cleared; a later ramp is not honoured.
    tick(1);
    cclr <= 5'h1f;
    ramp <= 1'h1;
    tick(1);
    cclr <= 5'h00;
    tick(9);
    #1 chk("sys_reset", 32'h0, 32'(sys));
    chk("tap_reset", 32'h0, 32'(tap));
    chk("cause", 32'h0, 32'(cause));
    // Brown-out: interrupt only, then reset once enabled.
    tick(1);
    ramp <= 1'h0;
    bint_en <= 1'h1;
    sag <= 1'h1;
    tick(8);
    #1 chk("bo_int", 32'h1, 32'(bint));
    chk("sys_reset", 32'h0, 32'(sys));
    tick(1);
    bor_en <= 1'h1;
    tick(28);
    #1 chk("sys_reset", 32'h1, 32'(sys));
    chk("cause", 32'h4, 32'(cause));
    tick(1);
    sag <= 1'h0;
    wait_for(1'h0, 1'h0, 40);
    // Soft peripheral resets in all three registers.
    tick(1);
    sr0 <= 32'h8000_0000;
    sr1 <= 32'h0000_0020;
    sr2 <= 32'h0000_0001;
    tick(3);
    {sr0, sr1, sr2} <= 96'h0;
    #1 chk("periph0", 32'h8000_0000, pr0);
    chk("periph1", 32'h0000_0020, pr1);
    chk("periph2", 32'h0000_0001, pr2);
    tick(3);
    #1 chk("periph", 32'h0, pr0 | pr1 | pr2);
    // System reset request.
    tick(1);
    sysreq <= 1'h1;
    tick(1);
    sysreq <= 1'h0;
    wait_for(1'h0, 1'h1, 6);
    wait_for(1'h0, 1'h0, 40);
    chk("cause", 32'h0000_000c, 32'(cause));
    // Watchdog: first time-out interrupts; second resets when enabled.
    tick(1);
    wdt_en <= 1'h1;
    wdt_ld <= 1'h1;
    tick(1);
    wdt_ld <= 1'h0;
    wait_for(1'h1, 1'h1, 60);
    chk("reload", reload, wcnt);
    tick(30);
    #1 chk("sys_reset", 32'h0, 32'(sys));
    tick(1);
    int_clr <= 1'h1;
    wdt_rst_en <= 1'h1;
    tick(1);
    int_clr <= 1'h0;
    wait_for(1'h1, 1'h1, 60);
    wait_for(1'h0, 1'h1, 60);
    chk("cause", 32'h0000_001c, 32'(cause));
    wait_for(1'h0, 1'h0, 60);
    // Second controller reset in mid-run clears the causes.
    tick(1);
    srst <= 1'h1;
    tick(2);
    srst <= 1'h0;
    #1 chk("cause", 32'h0, 32'(cause));
    wait_for(1'h0, 1'h0, 40);
    end_of_test();
  end
endmodule
